// File: pkg/flash_access_map.vh
// Purpose: constants for the flash access control block
// Assumes: word index = printed offset, byte address = 4 * index
// Notes:   definitions only
`ifndef FLASH_ACCESS_MAP_VH
`define FLASH_ACCESS_MAP_VH

// register word indices (haddr[15:2])
`define IDX_CTRL_ONE     14'h0fd0
`define IDX_KEY_MON      14'h0fd1
`define IDX_STANDBY      14'h0fd2
`define IDX_PORT_GATE    14'h0fd3
`define IDX_SYS_CTRL3    14'h0fd4
`define IDX_SYS_KEY      14'h0fd5

// control_one fields
`define PROT_HI          7
`define PROT_LO          5
`define ROM_SHOW_BIT     4
`define AREA_HI          3
`define AREA_LO          2
`define CTRL_ONE_RST     8'h40

// field values and keys
`define PROT_ENABLE      3'h5
`define PROT_DISABLE     3'h2
`define AREA_STD         2'h0
`define AREA_MIRROR      2'h2
`define FLASH_KEY        8'hd5
`define SYS_KEY          8'hd4

// system_control_three fields
`define RAM_REMAP_BIT    0
`define VECTOR_LOC_BIT   1

// port_input_gate fields
`define GEN_IN_BIT       0
`define SCLK_IN_BIT      1

// memory map
`define FLASH_BASE_HI    2'h3
`define ROM_BASE         16'h1000
`define ROM_DATA_END     16'h17ff
`define ROM_CODE_END_SER 16'h1fff

// decoded targets
`define TGT_NONE         2'h0
`define TGT_FLASH        2'h1
`define TGT_ROM          2'h2
`define TGT_RAM          2'h3

// ahb-lite transfer type
`define HTRANS_NONSEQ    2'h2

`endif

// File: rtl/flash_access_control.v
// Purpose: flash standby, write protect, area mapping and port gating
// Assumes: core strobes are synchronous to i_core_clk; AHB-Lite slave
// Notes:   zero-wait bus; all outputs registered
//          i_clk_en low freezes every register, bus side included
`timescale 1ns/1ps
`include "flash_access_map.vh"

module flash_access_control (
    input  wire        i_core_clk,
    input  wire        i_rstn,
    input  wire        i_clk_en,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [15:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    // core side
    input  wire        i_serial_mode,
    input  wire        i_exec_in_ram,
    input  wire        i_flash_access,
    input  wire        i_irq_taken,
    input  wire        i_flash_cmd_wr,
    input  wire        i_flash_toggle_rd,
    input  wire [15:0] i_code_addr,
    input  wire [15:0] i_data_addr,
    output reg         o_standby_reset,
    output reg         o_flash_standby,
    output reg         o_flash_cmd_wr,
    output reg         o_flash_toggle_rd,
    output reg  [1:0]  o_code_target,
    output reg  [1:0]  o_data_target,
    output reg  [13:0] o_flash_offset,
    output reg         o_sclk_in_en,
    output reg         o_port_in_en
);

    // bus address phase capture
    reg        wr_pend_r;
    reg [13:0] wr_idx_r;
    reg        wr_ram_r;

    // software-visible state
    reg [7:0]  ctrl_one_r;
    reg [2:0]  prot_act_r;
    reg        rom_act_r;
    reg [1:0]  area_act_r;
    reg [1:0]  sys3_r;
    reg        remap_act_r;
    reg        vec_ram_act_r;
    reg        standby_r;
    reg [1:0]  gate_r;

    // next values
    reg [7:0]  rd_nxt;
    reg        standby_nxt;
    reg [1:0]  code_tgt_nxt;
    reg [1:0]  data_tgt_nxt;

    wire       addr_ok;
    wire       wr_now;
    // data-phase write strobes, one per register or key
    wire       ctrl_wr;
    wire       flash_commit;
    wire       sys3_wr;
    wire       sys_commit;
    wire       gate_wr;
    wire       sby_wr;
    wire       cmd_en;
    wire       rom_shown;
    wire       ram_in_code;
    wire [7:0] wbyte;
    wire [7:0] monitor;

    // decode helper: address falls in the top flash quarter
    function in_flash;
        input [15:0] a;
        begin
            in_flash = (a[15:14] == `FLASH_BASE_HI);
        end
    endfunction

    // decode helper: address inside a loader rom window
    function in_rom;
        input [15:0] a;
        input [15:0] hi;
        begin
            in_rom = (a >= `ROM_BASE) && (a <= hi);
        end
    endfunction

    // decode helper: pending data-phase write aimed at one register
    function reg_hit;
        input        pend;
        input [13:0] idx;
        input [13:0] want;
        begin
            reg_hit = pend && (idx == want);
        end
    endfunction

    // decode helper: key write; any other byte is ignored, so a stray
    // store to the key address cannot commit half-written settings
    function key_hit;
        input       hit;
        input [7:0] d;
        input [7:0] key;
        begin
            key_hit = hit && (d == key);
        end
    endfunction

    assign addr_ok = hsel && hready && (htrans == `HTRANS_NONSEQ);
    assign wr_now  = wr_pend_r;
    assign wbyte   = hwdata[7:0];

    // write strobes; the commit keys only count at their own address
    assign ctrl_wr      = reg_hit(wr_now, wr_idx_r, `IDX_CTRL_ONE);
    assign sys3_wr      = reg_hit(wr_now, wr_idx_r, `IDX_SYS_CTRL3);
    assign gate_wr      = reg_hit(wr_now, wr_idx_r, `IDX_PORT_GATE);
    assign sby_wr       = reg_hit(wr_now, wr_idx_r, `IDX_STANDBY);
    assign flash_commit = key_hit(reg_hit(wr_now, wr_idx_r, `IDX_KEY_MON),
                                  wbyte, `FLASH_KEY);
    assign sys_commit   = key_hit(reg_hit(wr_now, wr_idx_r, `IDX_SYS_KEY),
                                  wbyte, `SYS_KEY);

    // only the committed copy gates the flash
    // a staged but uncommitted value never opens the flash by itself
    assign cmd_en      = (prot_act_r == `PROT_ENABLE);
    assign rom_shown   = rom_act_r | i_serial_mode;
    assign ram_in_code = remap_act_r | i_serial_mode;

    // monitor view of the shadow; top two bits read 0
    // bits 1:0 carry no setting in this block and read 0 as well
    assign monitor = {2'b00, cmd_en, rom_shown, area_act_r,
                      2'b00};

    // address phase: register write intent and instruction source
    // the source is sampled with the address, as the store issues
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 14'h0000;
            wr_ram_r  <= 1'b0;
        end else if (i_clk_en) begin
            if (hready) begin
                wr_pend_r <= addr_ok && hwrite;
                wr_idx_r  <= haddr[15:2];
                wr_ram_r  <= i_exec_in_ram;
            end
        end
    end

    // read mux, captured in the address phase for zero-wait data;
    // a read straight after a write to the same register sees the
    // old value, as the write only lands at the end of its data phase
    always @* begin
        rd_nxt = 8'h00;
        case (haddr[15:2])
            `IDX_CTRL_ONE: begin
                rd_nxt = ctrl_one_r;
                if (i_serial_mode)
                    rd_nxt[`ROM_SHOW_BIT] = 1'b1;
            end
            `IDX_KEY_MON:   rd_nxt = monitor;
            `IDX_STANDBY:   rd_nxt = 8'h00;
            `IDX_PORT_GATE: rd_nxt = i_serial_mode ?
                                     {6'h00, gate_r} : 8'h00;
            `IDX_SYS_CTRL3: rd_nxt = {6'h00, sys3_r};
            default:        rd_nxt = 8'h00;
        endcase
    end

    // bus answer: always ready, always okay, unmapped reads give zero;
    // hreadyout stays high while i_clk_en is low, so the master must
    // not start a transfer then: it would be dropped without notice
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else if (i_clk_en) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ok && !hwrite)
                hrdata <= {24'h00_0000, rd_nxt};
        end
    end

    // control_one staging register and its committed shadow
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_one_r <= `CTRL_ONE_RST;
            prot_act_r <= `PROT_DISABLE;
            rom_act_r  <= 1'b0;
            area_act_r <= `AREA_STD;
        end else if (i_clk_en) begin
            // serial mode pins the show bit: a write leaves it alone
            if (ctrl_wr && i_serial_mode)
                ctrl_one_r <= {wbyte[`PROT_HI:`PROT_LO],
                               ctrl_one_r[`ROM_SHOW_BIT],
                               wbyte[`AREA_HI:0]};
            else if (ctrl_wr)
                ctrl_one_r <= wbyte;
            // commit copies staging into the shadow in one step
            if (flash_commit) begin
                prot_act_r <= ctrl_one_r[`PROT_HI:`PROT_LO];
                rom_act_r  <= ctrl_one_r[`ROM_SHOW_BIT];
                area_act_r <= ctrl_one_r[`AREA_HI:`AREA_LO];
            end
        end
    end

    // system control three and its key-committed copy
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sys3_r        <= 2'b00;
            remap_act_r   <= 1'b0;
            vec_ram_act_r <= 1'b0;
        end else if (i_clk_en) begin
            if (sys3_wr)
                sys3_r <= wbyte[1:0];
            // the key makes both bits live in the same cycle
            if (sys_commit) begin
                remap_act_r   <= sys3_r[`RAM_REMAP_BIT];
                vec_ram_act_r <= sys3_r[`VECTOR_LOC_BIT];
            end
        end
    end

    // port input gate: writable only in serial programming mode; the
    // bits keep their value across a mode change, only the use differs
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            gate_r <= 2'b00;
        end else if (i_clk_en && gate_wr && i_serial_mode) begin
            gate_r <= wbyte[1:0];
        end
    end

    // standby bit: interrupt clear, then a RAM-sourced write
    always @* begin
        standby_nxt = standby_r;
        // vectors in flash: clear before the vector fetch hits flash
        if (i_irq_taken && !vec_ram_act_r)
            standby_nxt = 1'b0;
        // vectors in RAM: the bit is left alone, so a vector kept in
        // flash would then trip the standby reset
        else if (i_irq_taken)
            standby_nxt = standby_r;
        // a store from RAM wins over a same-cycle interrupt clear;
        // a store from flash code is dropped
        if (sby_wr && wr_ram_r)
            standby_nxt = wbyte[0];
    end

    // standby bit register
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            standby_r <= 1'b0;
        end else if (i_clk_en) begin
            standby_r <= standby_nxt;
        end
    end

    // standby reset: any fetch, read or write to flash while asleep
    // the reset follows i_flash_access one cycle late, for as long as it lasts; the system reset logic holds it
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_standby_reset <= 1'b0;
            o_flash_standby <= 1'b0;
        end else if (i_clk_en) begin
            o_standby_reset <= standby_r && i_flash_access;
            o_flash_standby <= standby_r;
        end
    end

    // command and toggle gating; a sequence already inside the flash
    // is not touched, only new strobes are dropped; software must let
    // a running sequence finish before it commits the disable value
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_flash_cmd_wr    <= 1'b0;
            o_flash_toggle_rd <= 1'b0;
        end else if (i_clk_en) begin
            o_flash_cmd_wr    <= i_flash_cmd_wr && cmd_en;
            o_flash_toggle_rd <= i_flash_toggle_rd && cmd_en;
        end
    end

    // code-space decode: rom overlay, then RAM remap, then flash
    // the serial loader window reaches further in code than in data
    always @* begin
        code_tgt_nxt = `TGT_NONE;
        if (i_serial_mode && in_rom(i_code_addr, `ROM_CODE_END_SER))
            code_tgt_nxt = `TGT_ROM;
        else if (rom_shown && in_rom(i_code_addr, `ROM_DATA_END))
            code_tgt_nxt = `TGT_ROM;
        else if (ram_in_code && i_code_addr[15:12] == 4'h0)
            code_tgt_nxt = `TGT_RAM;
        else if (in_flash(i_code_addr))
            code_tgt_nxt = `TGT_FLASH;
    end

    // data-space decode; transfers see flash only via this window
    // RAM remap is left out here: it only moves instruction fetches
    always @* begin
        data_tgt_nxt = `TGT_NONE;
        if (rom_shown && in_rom(i_data_addr, `ROM_DATA_END))
            data_tgt_nxt = `TGT_ROM;
        else if (in_flash(i_data_addr))
            data_tgt_nxt = `TGT_FLASH;
    end

    // targets and the shared physical offset; the mirror setting only
    // shows in the monitor area bits and moves neither window nor cell;
    // the offset follows the data address every cycle, so it means
    // something only while the data target is flash
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_code_target  <= `TGT_NONE;
            o_data_target  <= `TGT_NONE;
            o_flash_offset <= 14'h0000;
        end else if (i_clk_en) begin
            o_code_target  <= code_tgt_nxt;
            o_data_target  <= data_tgt_nxt;
            o_flash_offset <= i_data_addr[13:0];
        end
    end

    // port input enables: forced on outside serial programming mode
    // both read low during reset and settle one clock after release
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sclk_in_en <= 1'b0;
            o_port_in_en <= 1'b0;
        end else if (i_clk_en) begin
            o_sclk_in_en <= !i_serial_mode ||
                            gate_r[`SCLK_IN_BIT];
            o_port_in_en <= !i_serial_mode ||
                            gate_r[`GEN_IN_BIT];
        end
    end

endmodule // flash_access_control

// File: verification/flash_access_monitor.sv
// Purpose: assertion checker on the flash_access_control ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to the design at the foot of this file
`timescale 1ns/1ps
`include "flash_access_map.vh"

module flash_access_monitor (
    input wire        i_core_clk,
    input wire        i_rstn,
    input wire        i_clk_en,
    input wire        hsel,
    input wire [15:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        i_serial_mode,
    input wire        i_flash_access,
    input wire        i_flash_cmd_wr,
    input wire        i_flash_toggle_rd,
    input wire [15:0] i_code_addr,
    input wire [15:0] i_data_addr,
    input wire        o_standby_reset,
    input wire        o_flash_cmd_wr,
    input wire        o_flash_toggle_rd,
    input wire [1:0]  o_code_target,
    input wire [1:0]  o_data_target,
    input wire [13:0] o_flash_offset,
    input wire        o_sclk_in_en,
    input wire        o_port_in_en
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    // read accepted in its address phase; data shows one cycle on
    wire rd_go = hsel && hready && (htrans == `HTRANS_NONSEQ) && !hwrite;

    AST_CMD_PASS: assert property (
        o_flash_cmd_wr |-> $past(i_flash_cmd_wr))
        else $error("command strobe without a core request");
    AST_TOG_PASS: assert property (
        o_flash_toggle_rd |-> $past(i_flash_toggle_rd))
        else $error("toggle strobe without a core request");
    AST_SBY_CAUSE: assert property (
        o_standby_reset |-> $past(i_flash_access))
        else $error("standby reset without a flash access");
    AST_GATE_MCU: assert property (
        $past(i_rstn) && $past(i_clk_en) && !$past(i_serial_mode)
        |-> o_sclk_in_en && o_port_in_en)
        else $error("port input disabled outside serial mode");
    AST_SBY_READ: assert property (
        rd_go && haddr[15:2] == `IDX_STANDBY |=> hrdata == 32'h0)
        else $error("standby register read not zero");
    AST_GATE_READ: assert property (
        rd_go && !i_serial_mode && haddr[15:2] == `IDX_PORT_GATE
        |=> hrdata == 32'h0)
        else $error("gate register read not zero in core mode");
    AST_CODE_ROM: assert property (
        o_code_target == `TGT_ROM |-> $past(i_code_addr) >= `ROM_BASE &&
        $past(i_code_addr) <= ($past(i_serial_mode) ? 16'h1fff : 16'h17ff))
        else $error("loader rom decoded outside its code range");
    AST_DATA_ROM: assert property (
        o_data_target == `TGT_ROM |-> $past(i_data_addr) >= `ROM_BASE &&
        $past(i_data_addr) <= `ROM_DATA_END)
        else $error("loader rom decoded outside its data range");
    AST_DATA_FLASH: assert property (
        o_data_target == `TGT_FLASH |-> o_flash_offset ==
        $past(i_data_addr[13:0]) && $past(i_data_addr[15:14]) == 2'h3)
        else $error("flash data decode or offset wrong");
endmodule // flash_access_monitor

bind flash_access_control flash_access_monitor flash_access_monitor_inst (
    .i_core_clk, .i_rstn, .i_clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hrdata,
    .i_serial_mode, .i_flash_access, .i_flash_cmd_wr, .i_flash_toggle_rd,
    .i_code_addr, .i_data_addr, .o_standby_reset, .o_flash_cmd_wr,
    .o_flash_toggle_rd, .o_code_target, .o_data_target, .o_flash_offset,
    .o_sclk_in_en, .o_port_in_en);

// File: verification/core_model.sv
// Purpose: core-side model issuing flash strobes and fetch addresses
// Assumes: changes only just after a rising edge, like the real core
// Notes:   strobes last one cycle; addresses stand until replaced
`timescale 1ns/1ps

module core_model (
    input  wire         i_core_clk,
    output logic        o_flash_access = 1'b0,
    output logic        o_irq_taken = 1'b0,
    output logic        o_flash_cmd_wr = 1'b0,
    output logic        o_flash_toggle_rd = 1'b0,
    output logic [15:0] o_code_addr = 16'h0000,
    output logic [15:0] o_data_addr = 16'h0000
);
    // one-cycle strobes {access, irq, cmd, toggle}; single command
    // writes only, so no sequence is left open at a disable
    task automatic pulse(input logic [3:0] s);
        @(posedge i_core_clk);
        {o_flash_access, o_irq_taken, o_flash_cmd_wr, o_flash_toggle_rd} <= s;
        @(posedge i_core_clk);
        {o_flash_access, o_irq_taken, o_flash_cmd_wr, o_flash_toggle_rd} <= 4'h0;
    endtask

    // present addresses; code and data may both point into flash
    task automatic point(input logic [15:0] c, input logic [15:0] d);
        @(posedge i_core_clk);
        o_code_addr <= c;
        o_data_addr <= d;
        @(posedge i_core_clk);
    endtask
endmodule // core_model

// File: verification/tb_top.sv
// Purpose: self-checking bench for flash_access_control
// Assumes: zero-wait AHB-Lite slave; core_model drives the core strobes
// Notes:   expected values come from the register map, not the design
`timescale 1ns/1ps
`include "flash_access_map.vh"

module tb_top;
    localparam logic [15:0] A_CTRL = {`IDX_CTRL_ONE, 2'b00};
    localparam logic [15:0] A_KEY  = {`IDX_KEY_MON, 2'b00};
    localparam logic [15:0] A_SBY  = {`IDX_STANDBY, 2'b00};
    localparam logic [15:0] A_GATE = {`IDX_PORT_GATE, 2'b00};
    localparam logic [15:0] A_SYS3 = {`IDX_SYS_CTRL3, 2'b00};
    localparam logic [15:0] A_SKEY = {`IDX_SYS_KEY, 2'b00};
    logic        i_core_clk = 1'b0;
    logic        i_rstn = 1'b0;
    logic        hsel = 1'b0;
    logic [15:0] haddr = 16'h0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0]  hsize = 3'h0;
    logic        i_clk_en = 1'b1;
    logic        i_serial_mode = 1'b0;
    logic        i_exec_in_ram = 1'b0;
    int          fail_count = 0;
    int          n_compared = 0;
    wire         hreadyout, hresp, o_standby_reset, o_flash_standby;
    wire         o_flash_cmd_wr, o_flash_toggle_rd, o_sclk_in_en, o_port_in_en;
    wire         i_flash_access, i_irq_taken, i_flash_cmd_wr, i_flash_toggle_rd;
    wire [31:0]  hrdata;
    wire [15:0]  i_code_addr, i_data_addr;
    wire [1:0]   o_code_target, o_data_target;
    wire [13:0]  o_flash_offset;

    always #50 i_core_clk = ~i_core_clk;

    flash_access_control flash_access_control_inst (
        .i_core_clk, .i_rstn, .i_clk_en, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .i_serial_mode, .i_exec_in_ram, .i_flash_access,
        .i_irq_taken, .i_flash_cmd_wr, .i_flash_toggle_rd, .i_code_addr,
        .i_data_addr, .o_standby_reset, .o_flash_standby, .o_flash_cmd_wr,
        .o_flash_toggle_rd, .o_code_target, .o_data_target, .o_flash_offset,
        .o_sclk_in_en, .o_port_in_en);

    core_model core_model_inst (
        .i_core_clk, .o_flash_access(i_flash_access), .o_irq_taken(i_irq_taken),
        .o_flash_cmd_wr(i_flash_cmd_wr), .o_flash_toggle_rd(i_flash_toggle_rd),
        .o_code_addr(i_code_addr), .o_data_addr(i_data_addr));

    task automatic results;
        $display("compared %0d, fail_count %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    // single word transfer; address phase held until hready is seen high
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] r);
        @(posedge i_core_clk);
        hsel <= 1'b1;
        htrans <= `HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge i_core_clk);
        while (hreadyout !== 1'b1) @(posedge i_core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hsize <= 3'h0;
        hwdata <= {24'h0, d};
        @(posedge i_core_clk);
        while (hreadyout !== 1'b1) @(posedge i_core_clk);
        r = hrdata[7:0];
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] r;
        bus(1'b0, a, 8'h00, r);
        cmp(r, e);
    endtask

    // strobe cmd and toggle, look in the one cycle the result stands
    task automatic cmdchk(input logic e);
        core_model_inst.pulse(4'h3);
        #1 cmp({o_flash_cmd_wr, o_flash_toggle_rd}, {2{e}});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    task automatic at(input logic [15:0] c, input logic [15:0] d);
        core_model_inst.point(c, d);
        #1;
    endtask

    // clock enable and mode pin change right after an edge, then settle
    task automatic set_mode(input logic en, input logic ser);
        @(posedge i_core_clk);
        i_clk_en <= en;
        i_serial_mode <= ser;
        settle(2);
    endtask

    // a hang counts as a mismatch and ends the run the normal way
    initial begin
        repeat (5000) @(posedge i_core_clk);
        fail_count++;
        results();
    end

    initial begin
        repeat (20) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        rd(A_CTRL, 8'h40);
        rd(A_KEY, 8'h00);
        cmp(o_flash_standby, 1'b0);
        cmdchk(1'b0);
        wr(A_CTRL, 8'ha0);
        cmdchk(1'b0);
        wr(A_KEY, `FLASH_KEY);
        rd(A_KEY, 8'h20);
        cmdchk(1'b1);
        wr(A_CTRL, 8'h58);
        wr(A_KEY, `SYS_KEY);
        cmdchk(1'b1);
        wr(A_KEY, `FLASH_KEY);
        rd(A_KEY, 8'h18);
        cmdchk(1'b0);
        at(16'hc123, 16'hc123);
        cmp({o_code_target, o_data_target}, 4'h5);
        cmp(o_flash_offset, 14'h0123);
        at(16'h1000, 16'h17ff);
        cmp({o_code_target, o_data_target}, 4'ha);
        at(16'h1800, 16'h1800);
        cmp({o_code_target, o_data_target}, 4'h0);
        wr(A_SYS3, 8'h01);
        at(16'h0100, 16'hc000);
        cmp(o_code_target, `TGT_NONE);
        wr(A_SKEY, `SYS_KEY);
        at(16'h0100, 16'hc000);
        cmp(o_code_target, `TGT_RAM);
        wr(A_SBY, 8'h01);
        settle(2);
        cmp(o_flash_standby, 1'b0);
        @(posedge i_core_clk) i_exec_in_ram <= 1'b1;
        wr(A_SBY, 8'h01);
        settle(2);
        cmp(o_flash_standby, 1'b1);
        rd(A_SBY, 8'h00);
        cmp({hreadyout, hresp}, 2'b10);
        core_model_inst.pulse(4'h8);
        #1 cmp(o_standby_reset, 1'b1);
        core_model_inst.pulse(4'h4);
        settle(2);
        cmp(o_flash_standby, 1'b0);
        wr(A_SYS3, 8'h02);
        wr(A_SKEY, `SYS_KEY);
        wr(A_SBY, 8'h01);
        core_model_inst.pulse(4'h4);
        settle(2);
        cmp(o_flash_standby, 1'b1);
        wr(A_SBY, 8'h00);
        wr(A_CTRL, 8'h48);
        wr(A_KEY, `FLASH_KEY);
        wr(A_GATE, 8'h03);
        rd(A_GATE, 8'h00);
        settle(2);
        cmp({o_sclk_in_en, o_port_in_en}, 2'b11);
        set_mode(1'b1, 1'b1);
        cmp({o_sclk_in_en, o_port_in_en}, 2'b00);
        wr(A_GATE, 8'h02);
        settle(2);
        cmp({o_sclk_in_en, o_port_in_en}, 2'b10);
        wr(A_GATE, 8'h01);
        settle(2);
        cmp({o_sclk_in_en, o_port_in_en}, 2'b01);
        rd(A_GATE, 8'h01);
        rd(A_CTRL, 8'h58);
        wr(A_CTRL, 8'h58);
        // frozen: leaving serial mode must not reach the enables yet
        set_mode(1'b0, 1'b0);
        cmp({o_sclk_in_en, o_port_in_en}, 2'b01);
        set_mode(1'b1, 1'b0);
        cmp({o_sclk_in_en, o_port_in_en}, 2'b11);
        rd(A_GATE, 8'h00);
        rd(A_CTRL, 8'h48);
        set_mode(1'b1, 1'b1);
        at(16'h1f00, 16'h1000);
        cmp({o_code_target, o_data_target}, 4'ha);
        at(16'h0100, 16'hc000);
        cmp(o_code_target, `TGT_RAM);
        results();
    end
endmodule // tb_top
